// file: core/setpoint_relay_logic.sv
// Setpoint relays, combined reading, ambient recalibration and defect handling
`timescale 1ns/1ns
module setpoint_relay_logic
  import setpoint_relay_pkg::*;
#(
  parameter int N_SP = 3
)
(
  input wire logic core_clk_in, // 100 MHz clock
  input wire logic rst_in, // Asynchronous reset, active high
  input wire logic sample_valid_in, // One new measurement this cycle
  input wire logic [P_W-1:0] thermal_in, // Thermal element reading, Torr counts
  input wire logic signed [P_W-1:0] diff_in, // Differential reading, Torr counts
  input wire logic sensor_fail_in, // Element failure detected
  input wire gas_t gas_in, // Selected gas
  input wire unit_t report_unit_in, // Reporting unit
  input wire unit_t display_unit_in, // Local display unit
  input wire logic safety_delay_switch_in, // 1 enables five sample delay
  input wire sp_cfg_t [N_SP-1:0] sp_cfg_in, // Setpoint configuration writes
  output logic [N_SP-1:0] relay_out, // Relay drive, 1 energized
  output logic signed [P_W-1:0] sp_hyst_out [N_SP], // Stored hysteresis values
  output logic [P_W-1:0] thermal_sensor_reading_out, // Thermal reading, report unit
  output logic signed [P_W-1:0] differential_reading_out, // Differential, report unit
  output logic [P_W-1:0] combined_reading_three_digit_out, // Combined, 3 digits
  output logic [P_W-1:0] combined_reading_four_digit_out, // Combined, 4 digits
  output logic [P_W-1:0] display_value_out, // Combined, display unit
  output logic [15:0] analog_code_out, // Analog output code
  output logic status_red_out, // Status indicator red
  output logic status_green_out, // Status indicator green
  output logic nv_write_out, // Pulse: store calibration
  output logic [P_W-1:0] nv_cal_out // Calibration value to store
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  // Keep nd significant digits, lim is 10^nd
  function automatic logic [P_W-1:0] keep_digits(input logic [P_W-1:0] v,
                                                  input logic [P_W-1:0] lim);
    logic [P_W-1:0] r;
    logic [P_W-1:0] step;
    r = v;
    step = 48'h1;
    for (int k = 0; k < 10; k++)
    begin
      if (v >= P_W'(lim * step))
        r = P_W'((v / (step * 48'ha)) * (step * 48'ha));
      step = P_W'(step * 48'ha);
    end
    return r;
  endfunction

  function automatic logic [P_W-1:0] to_unit(input logic [P_W-1:0] v, input unit_t u);
    logic [71:0] prod;
    logic [23:0] f;
    case (u)
      UNIT_MBAR: f = CONV_MBAR;
      UNIT_PASCAL: f = CONV_PASCAL;
      default: f = CONV_TORR;
    endcase
    prod = 72'(v) * 72'(f);
    return P_W'(prod >> CONV_SHIFT);
  endfunction

  function automatic logic signed [P_W-1:0] to_unit_s(input logic signed [P_W-1:0] v,
                                                      input unit_t u);
    logic [P_W-1:0] m;
    m = to_unit(v[P_W-1] ? P_W'(-v) : P_W'(v), u);
    return v[P_W-1] ? -$signed(m) : $signed(m);
  endfunction

  // One volt per decade from 1e-5 Torr, linear inside each decade
  function automatic logic [15:0] log_code(input logic [P_W-1:0] v);
    logic [15:0] c;
    logic [P_W-1:0] p;
    logic [P_W-1:0] frac;
    c = 16'h0;
    p = 48'h1;
    for (int k = 0; k < DECADES; k++)
    begin
      if (v >= p)
      begin
        frac = P_W'(((v - p) * 48'(CODE_PER_VOLT)) / (p * 48'h9));
        c = 16'(k * int'(CODE_PER_VOLT)) + 16'(frac);
      end
      p = P_W'(p * 48'ha);
    end
    return c;
  endfunction

  function automatic logic [P_W-1:0] abs_diff(input logic [P_W-1:0] a,
                                              input logic [P_W-1:0] b);
    return (a > b) ? P_W'(a - b) : P_W'(b - a);
  endfunction

  // ****************************************************************
  // Combined reading
  // ****************************************************************
  logic [P_W-1:0] cal_r, cal_nxt;
  logic [P_W-1:0] nv_cal_r, nv_cal_nxt;
  logic nv_write_r, nv_write_nxt;
  logic [P_W-1:0] absolute;
  logic [P_W-1:0] combined;
  logic [P_W-1:0] band_lo;
  logic [P_W-1:0] band_hi;
  logic [P_W-1:0] blend_span;
  logic signed [P_W:0] abs_sum;
  logic signed [P_W+1:0] blend_delta;

  always_comb
  begin
    // Absolute = ambient calibration plus differential, floored at zero
    abs_sum = $signed({1'b0, cal_r}) + (P_W+1)'(diff_in);
    absolute = abs_sum[P_W] ? '0 : abs_sum[P_W-1:0];
    case (gas_in)
      GAS_HYDROGEN:
      begin
        band_lo = BAND_H2_LO;
        band_hi = BAND_H2_HI;
      end
      GAS_ARGON, GAS_HELIUM, GAS_H2O:
      begin
        band_lo = BAND_AR_LO;
        band_hi = BAND_AR_HI;
      end
      default:
      begin
        band_lo = BAND_MP_LO;
        band_hi = BAND_MP_HI;
      end
    endcase
    blend_span = P_W'(band_hi - band_lo);
    blend_delta = $signed({2'b00, absolute}) - $signed({2'b00, thermal_in});
    if (thermal_in < band_lo)
      combined = thermal_in;
    else if (thermal_in > band_hi)
      combined = absolute;
    else
      // Weight moves linearly from thermal at band_lo to absolute at band_hi
      combined = P_W'($signed({2'b00, thermal_in}) +
                 (blend_delta * $signed({2'b00, P_W'(thermal_in - band_lo)}))
                 / $signed({2'b00, blend_span}));
  end

  // Recalibrate ambient at pump-down; NV copy only moves past the margin
  always_comb
  begin
    cal_nxt = cal_r;
    nv_cal_nxt = nv_cal_r;
    nv_write_nxt = 1'b0;
    if (sample_valid_in && !sensor_fail_in && thermal_in < PUMPDOWN_LIMIT)
    begin
      cal_nxt = diff_in[P_W-1] ? P_W'(-diff_in) : '0;
      if (abs_diff(cal_nxt, nv_cal_r) > NV_MARGIN)
      begin
        nv_cal_nxt = cal_nxt;
        nv_write_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cal_r <= NOMINAL_AMBIENT;
      nv_cal_r <= NOMINAL_AMBIENT;
      nv_write_r <= 1'b0;
    end
    else
    begin
      cal_r <= cal_nxt;
      nv_cal_r <= nv_cal_nxt;
      nv_write_r <= nv_write_nxt;
    end
  end

  assign nv_write_out = nv_write_r;
  assign nv_cal_out = nv_cal_r;

  // ****************************************************************
  // Mode and outputs
  // ****************************************************************
  mode_t mode_r, mode_nxt;
  logic [P_W-1:0] therm_o_r, therm_o_nxt;
  logic signed [P_W-1:0] diff_o_r, diff_o_nxt;
  logic [P_W-1:0] c3_r, c3_nxt;
  logic [P_W-1:0] c4_r, c4_nxt;
  logic [P_W-1:0] disp_r, disp_nxt;
  logic [15:0] analog_r, analog_nxt;
  logic [P_W-1:0] defect_val;
  logic [P_W-1:0] c3_torr;

  always_comb
  begin
    mode_nxt = mode_r;
    therm_o_nxt = therm_o_r;
    diff_o_nxt = diff_o_r;
    c3_nxt = c3_r;
    c4_nxt = c4_r;
    disp_nxt = disp_r;
    analog_nxt = analog_r;
    case (report_unit_in)
      UNIT_MBAR: defect_val = DEFECT_MBAR;
      UNIT_PASCAL: defect_val = DEFECT_PASCAL;
      default: defect_val = DEFECT_TORR;
    endcase
    c3_torr = keep_digits(combined, DIGITS_THREE);
    if (sample_valid_in)
    begin
      case (mode_r)
        MODE_NORMAL: mode_nxt = sensor_fail_in ? MODE_DEFECT : MODE_NORMAL;
        MODE_DEFECT: mode_nxt = sensor_fail_in ? MODE_DEFECT : MODE_NORMAL;
        default: mode_nxt = MODE_DEFECT;
      endcase
      diff_o_nxt = to_unit_s(diff_in, report_unit_in);
      if (sensor_fail_in)
      begin
        therm_o_nxt = defect_val;
        c3_nxt = defect_val;
        c4_nxt = defect_val;
        disp_nxt = to_unit(DEFECT_TORR, display_unit_in);
        analog_nxt = DEFECT_CODE;
      end
      else
      begin
        therm_o_nxt = keep_digits(to_unit(thermal_in, report_unit_in), DIGITS_FOUR);
        c3_nxt = keep_digits(to_unit(combined, report_unit_in), DIGITS_THREE);
        c4_nxt = keep_digits(to_unit(combined, report_unit_in), DIGITS_FOUR);
        // Display conversion never touches the reporting unit setting
        disp_nxt = keep_digits(to_unit(combined, display_unit_in), DIGITS_THREE);
        analog_nxt = log_code(c3_torr);
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      mode_r <= MODE_NORMAL;
      therm_o_r <= '0;
      diff_o_r <= '0;
      c3_r <= '0;
      c4_r <= '0;
      disp_r <= '0;
      analog_r <= '0;
    end
    else
    begin
      mode_r <= mode_nxt;
      therm_o_r <= therm_o_nxt;
      diff_o_r <= diff_o_nxt;
      c3_r <= c3_nxt;
      c4_r <= c4_nxt;
      disp_r <= disp_nxt;
      analog_r <= analog_nxt;
    end
  end

  assign thermal_sensor_reading_out = therm_o_r;
  assign differential_reading_out = diff_o_r;
  assign combined_reading_three_digit_out = c3_r;
  assign combined_reading_four_digit_out = c4_r;
  assign display_value_out = disp_r;
  assign analog_code_out = analog_r;
  assign status_red_out = mode_r[1];
  assign status_green_out = mode_r[0];

  // ****************************************************************
  // Setpoint channels
  // ****************************************************************
  logic signed [P_W-1:0] sp_val_r [N_SP];
  logic signed [P_W-1:0] sp_val_nxt [N_SP];
  logic [N_SP-1:0] sp_above_r, sp_above_nxt;
  logic signed [P_W-1:0] sp_hyst_r [N_SP];
  logic signed [P_W-1:0] sp_hyst_nxt [N_SP];
  logic [2:0] sp_cnt_r [N_SP];
  logic [2:0] sp_cnt_nxt [N_SP];
  logic [N_SP-1:0] relay_r, relay_nxt;

  always_comb
  begin
    logic signed [P_W-1:0] rd;
    logic signed [P_W-1:0] tenth;
    logic exceed;
    logic released;
    rd = '0;
    tenth = '0;
    exceed = 1'b0;
    released = 1'b0;
    for (int i = 0; i < N_SP; i++)
    begin
      sp_val_nxt[i] = sp_cfg_in[i].value_wr ? sp_cfg_in[i].value : sp_val_r[i];
      sp_above_nxt[i] = sp_cfg_in[i].dir_wr ? sp_cfg_in[i].dir_above : sp_above_r[i];
      sp_hyst_nxt[i] = sp_hyst_r[i];
      sp_cnt_nxt[i] = sp_cnt_r[i];
      relay_nxt[i] = relay_r[i];
      // Hysteresis written alongside a value/direction write loses to auto reload
      if (sp_cfg_in[i].hyst_wr)
        sp_hyst_nxt[i] = sp_cfg_in[i].hyst;
      if (sp_cfg_in[i].value_wr || sp_cfg_in[i].dir_wr)
      begin
        tenth = sp_val_nxt[i] / P_W'(HYST_DIV);
        if (tenth < 0)
          tenth = -tenth;
        sp_hyst_nxt[i] = sp_above_nxt[i] ? sp_val_nxt[i] - tenth
                                         : sp_val_nxt[i] + tenth;
      end
      rd = (sp_cfg_in[i].enable == SRC_DIFF) ? diff_in : $signed(combined);
      exceed = sp_above_r[i] ? (rd > sp_val_r[i]) : (rd < sp_val_r[i]);
      released = sp_above_r[i] ? (rd <= sp_hyst_r[i]) : (rd >= sp_hyst_r[i]);
      if (sp_cfg_in[i].enable == SRC_OFF)
      begin
        relay_nxt[i] = 1'b0;
        sp_cnt_nxt[i] = '0;
      end
      else if (sample_valid_in && !sensor_fail_in)
      begin
        sp_cnt_nxt[i] = exceed ? ((sp_cnt_r[i] == SAFETY_SAMPLES) ? sp_cnt_r[i]
                                  : sp_cnt_r[i] + 3'h1) : 3'h0;
        if (!relay_r[i] && exceed &&
            (!safety_delay_switch_in || sp_cnt_nxt[i] == SAFETY_SAMPLES))
          relay_nxt[i] = 1'b1;
        else if (relay_r[i] && released)
          relay_nxt[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sp_above_r <= '0;
      relay_r <= '0;
      for (int i = 0; i < N_SP; i++)
      begin
        sp_val_r[i] <= '0;
        sp_hyst_r[i] <= '0;
        sp_cnt_r[i] <= '0;
      end
    end
    else
    begin
      sp_above_r <= sp_above_nxt;
      relay_r <= relay_nxt;
      sp_val_r <= sp_val_nxt;
      sp_hyst_r <= sp_hyst_nxt;
      sp_cnt_r <= sp_cnt_nxt;
    end
  end

  assign relay_out = relay_r;
  assign sp_hyst_out = sp_hyst_r;

endmodule

// file: include/setpoint_relay_pkg.sv
// Shared constants and types of the pressure setpoint and combined reading logic
package setpoint_relay_pkg;

  // ****************************************************************
  // Pressure scale: one count is 1e-5 of the pressure unit
  // ****************************************************************
  localparam int P_W = 48;
  localparam logic [P_W-1:0] NOMINAL_AMBIENT = 48'h0000_0487_ab00; // 760 Torr
  localparam logic [P_W-1:0] PUMPDOWN_LIMIT = 48'h0000_0001_d4c0; // 1.2 Torr
  localparam logic [P_W-1:0] NV_MARGIN = 48'h0000_000f_4240; // 10 Torr
  localparam logic [P_W-1:0] BAND_MP_LO = 48'h0000_003d_0900; // 40 Torr
  localparam logic [P_W-1:0] BAND_MP_HI = 48'h0000_005b_8d80; // 60 Torr
  localparam logic [P_W-1:0] BAND_H2_LO = 48'h0000_0007_a120; // 5 Torr
  localparam logic [P_W-1:0] BAND_H2_HI = 48'h0000_000a_ae60; // 7 Torr
  localparam logic [P_W-1:0] BAND_AR_LO = 48'h0000_000a_ae60; // 7 Torr
  localparam logic [P_W-1:0] BAND_AR_HI = 48'h0000_000f_4240; // 10 Torr
  localparam logic [P_W-1:0] DEFECT_TORR = 48'h0000_389f_d980; // 9.500E+3
  localparam logic [P_W-1:0] DEFECT_MBAR = 48'h0000_4b66_5e40; // 1.265E+4
  localparam logic [P_W-1:0] DEFECT_PASCAL = 48'h001d_73fc_d100; // 1.265E+6

  // ****************************************************************
  // Unit conversion from Torr, Q16 factors
  // ****************************************************************
  localparam logic [23:0] CONV_TORR = 24'h01_0000;
  localparam logic [23:0] CONV_MBAR = 24'h01_554e; // 1.33322
  localparam logic [23:0] CONV_PASCAL = 24'h85_526e; // 133.322
  localparam int CONV_SHIFT = 16;

  // ****************************************************************
  // Sample counts, digits, analog scale
  // ****************************************************************
  localparam logic [2:0] SAFETY_SAMPLES = 3'h5;
  localparam int HYST_DIV = 10; // Auto hysteresis is 10 percent
  localparam logic [P_W-1:0] DIGITS_THREE = 48'h0000_0000_03e8;
  localparam logic [P_W-1:0] DIGITS_FOUR = 48'h0000_0000_2710;
  localparam int DECADES = 10;
  localparam logic [15:0] CODE_PER_VOLT = 16'h1999; // 16-bit code over 10 V
  localparam logic [15:0] DEFECT_CODE = 16'h0ccc; // 0.5 V

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {SRC_OFF = 2'h0, SRC_ABS = 2'h1, SRC_DIFF = 2'h2} sp_source_t;
  typedef enum logic [1:0] {UNIT_TORR = 2'h0, UNIT_MBAR = 2'h1, UNIT_PASCAL = 2'h2} unit_t;
  typedef enum logic [3:0] {
    GAS_NITROGEN = 4'h0, GAS_AIR = 4'h1, GAS_ARGON = 4'h2, GAS_HELIUM = 4'h3,
    GAS_HYDROGEN = 4'h4, GAS_H2O = 4'h5, GAS_NEON = 4'h6, GAS_CO2 = 4'h7, GAS_XENON = 4'h8
  } gas_t;
  typedef enum logic [1:0] {MODE_NORMAL = 2'b01, MODE_DEFECT = 2'b10} mode_t;

  typedef struct packed {
    logic value_wr; // Setpoint value write strobe
    logic signed [P_W-1:0] value;
    logic dir_wr; // Direction write strobe
    logic dir_above; // 1 above, 0 below
    logic hyst_wr; // Hysteresis write strobe
    logic signed [P_W-1:0] hyst;
    sp_source_t enable;
  } sp_cfg_t;

endpackage

// file: verification/setpoint_relay_checker.sv
// Concurrent checks on the ports of the setpoint relay logic
`timescale 1ns/1ns
module setpoint_relay_checker
  import setpoint_relay_pkg::*;
#(
  parameter int N_SP = 3
)
(
  input wire logic core_clk_in, // Clock
  input wire logic rst_in, // Reset
  input wire logic sample_valid_in, // Sample strobe
  input wire logic [P_W-1:0] thermal_in, // Thermal reading
  input wire logic sensor_fail_in, // Element failure
  input wire unit_t report_unit_in, // Reporting unit
  input wire sp_cfg_t [N_SP-1:0] sp_cfg_in, // Setpoint writes
  input wire logic [N_SP-1:0] relay_out, // Relays
  input wire logic signed [P_W-1:0] sp_hyst_out [N_SP], // Hysteresis
  input wire logic [P_W-1:0] thermal_sensor_reading_out, // Thermal out
  input wire logic [P_W-1:0] combined_reading_three_digit_out, // Combined out
  input wire logic [15:0] analog_code_out, // Analog code
  input wire logic status_red_out, // Red
  input wire logic status_green_out, // Green
  input wire logic nv_write_out, // Store pulse
  input wire logic [P_W-1:0] nv_cal_out // Stored calibration
);
  // ********************************
  // Shadow of channel 0 setpoint
  // ********************************
  logic signed [P_W-1:0] val_r, val_nxt, mag, hyst_exp;
  logic above_r, above_nxt, pump;
  logic [P_W-1:0] defect_exp;

  always_comb
  begin
    val_nxt = sp_cfg_in[0].value_wr ? sp_cfg_in[0].value : val_r;
    above_nxt = sp_cfg_in[0].dir_wr ? sp_cfg_in[0].dir_above : above_r;
    mag = (val_nxt < 0 ? -val_nxt : val_nxt) / HYST_DIV;
    hyst_exp = above_nxt ? val_nxt - mag : val_nxt + mag;
    pump = sample_valid_in && !sensor_fail_in && thermal_in < PUMPDOWN_LIMIT;
    defect_exp = report_unit_in == UNIT_MBAR ? DEFECT_MBAR :
                 report_unit_in == UNIT_PASCAL ? DEFECT_PASCAL : DEFECT_TORR;
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      val_r <= '0;
      above_r <= 1'b0;
    end
    else
    begin
      val_r <= val_nxt;
      above_r <= above_nxt;
    end
  end

  // ********************************
  // Assertions
  // ********************************
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  sequence fail_smp;
    sample_valid_in && sensor_fail_in;
  endsequence

  hyst_reload_a: assert property ((sp_cfg_in[0].value_wr || sp_cfg_in[0].dir_wr)
    |=> sp_hyst_out[0] == $past(hyst_exp)) else $error("auto hysteresis wrong");
  hyst_write_a: assert property ((sp_cfg_in[0].hyst_wr && !sp_cfg_in[0].value_wr
    && !sp_cfg_in[0].dir_wr) |=> sp_hyst_out[0] == $past(sp_cfg_in[0].hyst))
    else $error("hysteresis write lost");
  relay_off_a: assert property (sp_cfg_in[0].enable == SRC_OFF |=> !relay_out[0])
    else $error("disabled relay energized");
  relay_cause_a: assert property ($rose(relay_out[0])
    |-> $past(sample_valid_in && !sensor_fail_in)) else $error("relay rose without sample");
  relay_freeze_a: assert property (fail_smp ##0 sp_cfg_in[0].enable != SRC_OFF
    |=> relay_out[0] == $past(relay_out[0])) else $error("relay moved in defect");
  defect_read_a: assert property (fail_smp |=> thermal_sensor_reading_out ==
    $past(defect_exp) && combined_reading_three_digit_out == $past(defect_exp))
    else $error("defect reading wrong");
  defect_out_a: assert property (fail_smp |=> status_red_out && !status_green_out
    && analog_code_out == DEFECT_CODE) else $error("defect outputs wrong");
  nv_cause_a: assert property (nv_write_out |-> $past(pump))
    else $error("store without pump down");
  nv_margin_a: assert property (nv_write_out |-> (nv_cal_out > $past(nv_cal_out) ?
    nv_cal_out - $past(nv_cal_out) : $past(nv_cal_out) - nv_cal_out) > NV_MARGIN)
    else $error("store inside margin");
endmodule

bind setpoint_relay_logic setpoint_relay_checker #(.N_SP(N_SP)) i_checker (
  .core_clk_in, .rst_in, .sample_valid_in, .thermal_in, .sensor_fail_in, .report_unit_in,
  .sp_cfg_in, .relay_out, .sp_hyst_out, .thermal_sensor_reading_out,
  .combined_reading_three_digit_out, .analog_code_out, .status_red_out, .status_green_out,
  .nv_write_out, .nv_cal_out
);

// file: verification/sensor_head_model.sv
// Model of the sensing elements that deliver one measurement per strobe
`timescale 1ns/1ns
module sensor_head_model
  import setpoint_relay_pkg::*;
(
  input wire logic core_clk_in, // Clock
  output logic sample_valid_out, // Measurement strobe
  output logic [P_W-1:0] thermal_out, // Thermal element
  output logic signed [P_W-1:0] diff_out, // Differential element
  output logic fail_out // Element broken
);
  initial
  begin
    sample_valid_out = 1'b0;
    thermal_out = '0;
    diff_out = '0;
    fail_out = 1'b0;
  end

  // Off-strobe lines show the inverse so a stale sample cannot pass
  task automatic measure(input logic [P_W-1:0] t, input logic [P_W-1:0] d, input logic f);
    @(posedge core_clk_in);
    #1;
    sample_valid_out = 1'b1;
    thermal_out = t;
    diff_out = d;
    fail_out = f;
    @(posedge core_clk_in);
    #1;
    sample_valid_out = 1'b0;
    thermal_out = ~t;
    diff_out = ~d;
    fail_out = ~f;
  endtask
endmodule

// file: verification/pressure_setpoint_relay_logic_tb.sv
// Self-checking bench for the setpoint relay logic
`timescale 1ns/1ns
module pressure_setpoint_relay_logic_tb
  import setpoint_relay_pkg::*;
  ;
  localparam int N_SP = 3;
  localparam logic [P_W-1:0] AMB = 48'h55d_4a80;
  localparam logic [P_W-1:0] D6 = -48'sh5b_8d80;
  localparam logic [P_W-1:0] H40 = -48'sh3d_0900;
  localparam logic [P_W-1:0] D68 = -48'sh40d_9900;
  localparam logic [P_W-1:0] DEF_V [3] = '{DEFECT_TORR, DEFECT_MBAR, DEFECT_PASCAL};
  localparam logic [P_W-1:0] BL_T [3] = '{48'h4c_4b40, 48'h9_27c0, 48'hc_f850};
  localparam logic [P_W-1:0] BL_D [3] = '{D68, -48'sh45e_7820, -48'sh459_e440};
  localparam logic [P_W-1:0] BL_E [3] = '{48'h53_ec60, 48'h9_eb10, 48'he_1d48};

  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic safety_delay_switch_in = 1'b1;
  logic sample_valid_in, sensor_fail_in, status_red_out, status_green_out, nv_write_out;
  logic [P_W-1:0] thermal_in, thermal_sensor_reading_out, combined_reading_three_digit_out;
  logic [P_W-1:0] combined_reading_four_digit_out, display_value_out, nv_cal_out;
  logic signed [P_W-1:0] diff_in, differential_reading_out;
  logic signed [P_W-1:0] sp_hyst_out [N_SP];
  logic [N_SP-1:0] relay_out;
  logic [15:0] analog_code_out;
  gas_t gas_in = GAS_NITROGEN;
  unit_t report_unit_in = UNIT_TORR;
  unit_t display_unit_in = UNIT_TORR;
  sp_cfg_t [N_SP-1:0] sp_cfg_in = '0;
  int failures = 0;
  int check_count = 0;
  int n, k;

  always #5 core_clk_in = ~core_clk_in;

  sensor_head_model i_sensor (
    .core_clk_in, .sample_valid_out(sample_valid_in), .thermal_out(thermal_in),
    .diff_out(diff_in), .fail_out(sensor_fail_in)
  );

  setpoint_relay_logic #(.N_SP(N_SP)) i_dut (
    .core_clk_in, .rst_in, .sample_valid_in, .thermal_in, .diff_in, .sensor_fail_in,
    .gas_in, .report_unit_in, .display_unit_in, .safety_delay_switch_in, .sp_cfg_in,
    .relay_out, .sp_hyst_out, .thermal_sensor_reading_out, .differential_reading_out,
    .combined_reading_three_digit_out, .combined_reading_four_digit_out, .display_value_out,
    .analog_code_out, .status_red_out, .status_green_out, .nv_write_out, .nv_cal_out
  );

  // ********************************
  // Tasks
  // ********************************
  task automatic tick;
    @(posedge core_clk_in);
    #1;
  endtask

  task automatic check(input logic [P_W-1:0] seen, input logic [P_W-1:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic chk1(input logic seen, input logic exp);
    check({47'h0, seen}, {47'h0, exp});
  endtask

  task automatic sp_write(input int ch, input logic [2:0] wr, input logic [P_W-1:0] v,
                          input logic a);
    sp_cfg_in[ch].value_wr = wr[2];
    sp_cfg_in[ch].dir_wr = wr[1];
    sp_cfg_in[ch].hyst_wr = wr[0];
    sp_cfg_in[ch].value = v;
    sp_cfg_in[ch].hyst = v;
    sp_cfg_in[ch].dir_above = a;
    tick;
    sp_cfg_in[ch].value_wr = 1'b0;
    sp_cfg_in[ch].dir_wr = 1'b0;
    sp_cfg_in[ch].hyst_wr = 1'b0;
    tick;
  endtask

  // The store pulse lands on the edge that captures the sample, so the first look sees it
  task automatic nv_count(output int cnt);
    cnt = 0;
    repeat (3)
    begin
      if (nv_write_out === 1'b1)
        cnt++;
      tick;
    end
  endtask

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask

  task automatic finish_test;
    $display("comparisons %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ********************************
  // Tests
  // ********************************
  initial
  begin
    repeat (3) @(posedge core_clk_in);
    #1;
    rst_in = 1'b0;
    sp_cfg_in[0].enable = SRC_DIFF;
    sp_cfg_in[1].enable = SRC_ABS;
    chk1(status_green_out, 1'b1);
    i_sensor.measure(AMB, '0, 1'b0);
    check(thermal_sensor_reading_out, AMB);
    check(combined_reading_three_digit_out, NOMINAL_AMBIENT);
    check(combined_reading_four_digit_out, NOMINAL_AMBIENT);
    check(differential_reading_out, '0);
    check({32'h0, analog_code_out}, {32'h0, 16'hc5f4});
    end_test("ambient");
    sp_write(0, 3'b100, -48'sh4c_4b40, 1'b0);
    check(sp_hyst_out[0], -48'sh44_aa20);
    sp_write(0, 3'b010, -48'sh4c_4b40, 1'b1);
    check(sp_hyst_out[0], -48'sh53_ec60);
    sp_write(0, 3'b010, -48'sh4c_4b40, 1'b0);
    sp_write(0, 3'b001, H40, 1'b0);
    check(sp_hyst_out[0], H40);
    end_test("hysteresis");
    repeat (4) i_sensor.measure(AMB, D6, 1'b0);
    chk1(relay_out[0], 1'b0);
    i_sensor.measure(AMB, -48'sh4a_c4a0, 1'b0);
    repeat (4) i_sensor.measure(AMB, D6, 1'b0);
    chk1(relay_out[0], 1'b0);
    i_sensor.measure(AMB, D6, 1'b0);
    chk1(relay_out[0], 1'b1);
    i_sensor.measure(AMB, -48'sh44_aa20, 1'b0);
    chk1(relay_out[0], 1'b1);
    i_sensor.measure(AMB, H40, 1'b0);
    chk1(relay_out[0], 1'b0);
    safety_delay_switch_in = 1'b0;
    i_sensor.measure(AMB, D6, 1'b0);
    chk1(relay_out[0], 1'b1);
    sp_cfg_in[0].enable = SRC_OFF;
    tick;
    chk1(relay_out[0], 1'b0);
    end_test("relay");
    sp_cfg_in[0].enable = SRC_DIFF;
    i_sensor.measure(AMB, D6, 1'b0);
    safety_delay_switch_in = 1'b1;
    for (int u = 0; u < 3; u++)
    begin
      report_unit_in = unit_t'(u);
      i_sensor.measure(AMB, -48'sh2d_c6c0, 1'b1);
      check(thermal_sensor_reading_out, DEF_V[u]);
      check(combined_reading_four_digit_out, DEF_V[u]);
      chk1(relay_out[0], 1'b1);
      chk1(status_red_out, 1'b1);
      check({32'h0, analog_code_out}, {32'h0, DEFECT_CODE});
    end
    report_unit_in = UNIT_TORR;
    i_sensor.measure(AMB, -48'sh2d_c6c0, 1'b0);
    chk1(relay_out[0], 1'b0);
    chk1(status_green_out, 1'b1);
    end_test("defect");
    sp_cfg_in[0].enable = SRC_OFF;
    safety_delay_switch_in = 1'b0;
    sp_write(1, 3'b110, 48'h2fa_f080, 1'b0);
    i_sensor.measure(48'h1_86a0, -48'sh478_68c0, 1'b0);
    chk1(relay_out[1], 1'b1);
    nv_count(n);
    check(48'(n), 48'h0);
    i_sensor.measure(48'h1_86a0, -48'sh469_2680, 1'b0);
    nv_count(n);
    check(48'(n), 48'h1);
    check(nv_cal_out, 48'h469_2680);
    i_sensor.measure(AMB, '0, 1'b0);
    check(combined_reading_three_digit_out, 48'h469_2680);
    end_test("calibration");
    for (int g = 0; g < 9; g++)
    begin
      gas_in = gas_t'(g);
      k = (gas_in == GAS_HYDROGEN) ? 1 : (gas_in inside {GAS_ARGON, GAS_HELIUM, GAS_H2O}) ? 2 : 0;
      i_sensor.measure(BL_T[k], BL_D[k], 1'b0);
      check(combined_reading_three_digit_out, BL_E[k]);
      check(combined_reading_four_digit_out, BL_E[k]);
    end
    gas_in = GAS_NITROGEN;
    i_sensor.measure(48'h12_d687, D68, 1'b0);
    check(combined_reading_three_digit_out, 48'h12_c4b0);
    check(combined_reading_four_digit_out, 48'h12_d450);
    check(thermal_sensor_reading_out, 48'h12_d450);
    display_unit_in = UNIT_MBAR;
    i_sensor.measure(48'h6a_cfc0, D68, 1'b0);
    check(combined_reading_three_digit_out, 48'h5b_8d80);
    check(display_value_out, 48'h79_eaf0);
    end_test("combined");
    finish_test;
  end

  initial
  begin
    #100000;
    failures++;
    finish_test;
  end
endmodule
